// file: dv/ptf_framer_tb.sv
// Purpose: Self-checking bench for the TDM frame builder and parser
// Assumes: Transmit line looped back through the far-end model
// Notes: Signalling bit set and voice LSB clear, so robbed words stand out
`timescale 1ns/1ps
module ptf_framer_tb
  import ptf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic fmt_long = 1'b0;
  logic [7:0] tx_word = 8'h00;
  logic tx_sig = 1'b0;
  logic [4:0] tx_slot;
  logic [4:0] rx_slot;
  logic [7:0] rx_word;
  logic signed [14:0] smp_out;
  logic tx_take, line_pos, line_neg, line_nrz, line_bclk_en;
  logic rx_bit, rx_bclk, rx_fsync, rx_vld, sig_out, smp_vld;
  int error_cnt = 0;
  int tests_run = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // Design and its far end
  ptf_framer u_dut (.clk_sys(clk_sys), .srst(srst), .fmt_long(fmt_long),
    .tx_word(tx_word), .tx_sig(tx_sig), .tx_slot(tx_slot), .tx_take(tx_take),
    .line_pos(line_pos), .line_neg(line_neg), .line_nrz(line_nrz),
    .line_bclk_en(line_bclk_en), .rx_bit_pin(rx_bit), .rx_bclk_pin(rx_bclk),
    .rx_fsync_pin(rx_fsync), .rx_vld(rx_vld), .rx_slot(rx_slot), .rx_word(rx_word),
    .received_signalling_output(sig_out), .smp_vld(smp_vld), .smp_out(smp_out));
  ptf_line_peer u_peer (.clk_sys(clk_sys), .srst(srst), .fmt_long(fmt_long),
    .line_pos(line_pos), .line_neg(line_neg), .line_bclk_en(line_bclk_en),
    .rx_bit(rx_bit), .rx_bclk(rx_bclk), .rx_fsync(rx_fsync));

  task automatic ck(input bit bad, input string msg);
    tests_run++;
    if (bad)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : ck

  task automatic results();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Word expected in a slot; long format fixes slots 0 and 16
  function automatic logic [7:0] slot_word(input logic [4:0] s);
    return (fmt_long && s == SLOT_SYNC) ? SYNC_WORD :
      (fmt_long && s == SLOT_SIG) ? SIG_SLOT_IDLE : tx_word;
  endfunction : slot_word

  // Interval midpoint in half steps; a robbed LSB counts as one half
  function automatic logic signed [14:0] exp_smp(input logic [7:0] w, input logic half);
    int mag;
    mag = (half ? w[3:1] * 4 + 2 : w[3:0] * 2 + 1) + 32;
    mag = mag << w[6:4];
    return 15'(w[7] ? mag : -mag);
  endfunction : exp_smp

  // Reset lands mid-run too, so stale frame state must be cleared
  task automatic start(input logic lng, input logic [7:0] w);
    @(negedge clk_sys);
    srst = 1'b1;
    fmt_long = lng;
    tx_word = w;
    tx_sig = 1'b1;
    repeat (2) @(negedge clk_sys);
    ck({tx_take, line_pos, line_neg, rx_vld, smp_vld, sig_out} !== 6'h00, "outputs in reset");
    srst = 1'b0;
  endtask : start

  // Watch line and receive side together until enough frames came back
  task automatic run(input int frames, output int sig_words);
    int nsl = fmt_long ? 32 : 24;
    int nb = 0, nf = 0, cyc = 0, t0 = 0, bi = 9, nrx = 0, prv_tx = -1, prv_rx = nsl - 1;
    logic [7:0] sh, ew;
    logic lp = 1'b0, fb = 1'b0, mk = 1'b0, armed = 1'b0, half, fhalf = 1'b0, pend = 1'b0;
    logic signed [14:0] es;
    logic bp = 1'b0; // Line bit pulse seen on the previous edge
    logic [4:0] slot;
    sig_words = 0;
    while (nrx <= frames)
    begin
      @(negedge clk_sys);
      cyc++;
      if (pend)
        ck(smp_vld !== 1'b1 || smp_out !== es, "decoded sample");
      pend = 1'b0;
      // Line outputs settle one cycle after the bit pulse, so judge them then
      if (bp)
      begin
        ck((line_pos | line_neg) !== line_nrz || (line_pos & line_neg) !== 0, "mark");
        if (line_nrz === 1'b1 && mk)
          ck(line_pos === lp, "mark polarity repeated");
        if (line_nrz === 1'b1)
          lp = line_pos;
        mk = mk | (line_nrz === 1'b1);
        if (tx_take === 1'b1)
        begin
          ck(tx_slot !== 5'((prv_tx + 1) % nsl), "transmit slot order");
          if (tx_slot === 5'h00 && nf > 0)
            ck(nb !== int'(fmt_long ? BITS_LONG : BITS_SHORT) || cyc - t0 > 12502
              || cyc - t0 < 12498, "frame length or rate");
          if (tx_slot === 5'h00)
          begin
            nf++;
            nb = 0;
            t0 = cyc;
          end
          prv_tx = tx_slot;
          slot = tx_slot;
          bi = 0;
        end
        nb++;
        if (bi < 8)
        begin
          sh = {sh[6:0], line_nrz};
          bi++;
          ew = slot_word(slot);
          if (bi == 8 && fmt_long)
            ck(sh !== (ew ^ INV_MASK), "long word on line");
          if (bi == 8 && !fmt_long)
            ck(sh[7:1] !== ew[7:1] || (sh[0] !== ew[0] && sh[0] !== tx_sig), "short");
        end
        else
        begin
          ck(fmt_long !== 1'b0 || (nf > 1 && line_nrz === fb), "framing bit");
          fb = line_nrz;
          bi++;
        end
      end
      bp = (line_bclk_en === 1'b1);
      if (rx_vld === 1'b1)
      begin
        armed = armed | (rx_slot === 5'h00 && nf > 0);
        if (armed && rx_slot === 5'h00)
          nrx++;
        if (armed && nrx <= frames)
        begin
          ew = slot_word(rx_slot);
          half = !fmt_long && rx_word[0] !== ew[0];
          ck(rx_slot !== 5'((prv_rx + 1) % nsl), "receive slot order");
          ck(rx_word !== (half ? {ew[7:1], tx_sig} : ew), "received word");
          if (half)
            ck(sig_out !== tx_sig, "signalling output");
          if (rx_slot === 5'h00)
            fhalf = half;
          ck(half !== fhalf, "signalling frame split");
          sig_words += half;
          es = exp_smp(ew, half);
          pend = 1'b1;
          prv_rx = rx_slot;
        end
      end
    end
  endtask : run

  task automatic scen_long();
    int sw;
    start(1'b1, 8'h3a);
    run(1, sw);
    ck(sw !== 0, "long format robbed a bit");
  endtask : scen_long

  // One robbed frame in every six
  task automatic scen_short();
    int sw;
    start(1'b0, 8'hc6);
    run(6, sw);
    ck(sw !== 24, "signalling word count");
  endtask : scen_short

  // Main sequence; the short run follows a reset in mid-frame
  initial
  begin
    scen_long();
    scen_short();
    results();
  end

  // Watchdog: both runs need about 0.9 ms
  initial
  begin
    #1000000;
    error_cnt++;
    results();
  end
endmodule : ptf_framer_tb

// file: dv/ptf_line_peer.sv
// Purpose: Far end in loopback: line decoder plus remote terminal timing
// Assumes: First line bit after reset is slot 0 MSB
// Notes: Strobe rises 2 cycles after the data, falls 8 cycles later
`timescale 1ns/1ps
module ptf_line_peer
  import ptf_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset
  input wire logic fmt_long, // 1 = 32-slot format
  input wire logic line_pos, // AMI positive mark
  input wire logic line_neg, // AMI negative mark
  input wire logic line_bclk_en, // Pulse per line bit
  output logic rx_bit, // Recovered NRZ bit
  output logic rx_bclk, // Bit strobe level
  output logic rx_fsync // Framing position mark
);
  logic [8:0] pos_r; // Bit position in frame
  logic [3:0] hold_r; // Strobe timer, 0 = idle
  logic [8:0] last_pos; // Final bit position of a frame
  logic en_d_r; // Bit pulse delayed to the cycle its line value settles

  // Frame length follows the format
  assign last_pos = fmt_long ? BITS_LONG - 9'h001 : BITS_SHORT - 9'h001;

  // Data settles before the strobe so the receiver never sees a moving bit;
  // line outputs lag their bit pulse by one cycle, hence the delayed pulse
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pos_r <= 9'h000;
      hold_r <= 4'h0;
      en_d_r <= 1'b0;
      rx_bit <= 1'b0;
      rx_bclk <= 1'b0;
      rx_fsync <= 1'b0;
    end
    else
    begin
      en_d_r <= line_bclk_en;
      if (en_d_r)
      begin
        rx_bit <= line_pos | line_neg;
        rx_fsync <= fmt_long ? (pos_r == 9'h000) : (pos_r == last_pos);
        pos_r <= (pos_r == last_pos) ? 9'h000 : pos_r + 9'h001;
        rx_bclk <= 1'b0;
        hold_r <= 4'h1;
      end
      else if (hold_r != 4'h0)
      begin
        hold_r <= (hold_r == 4'ha) ? 4'h0 : hold_r + 4'h1;
        if (hold_r == 4'h2)
          rx_bclk <= 1'b1;
        if (hold_r == 4'ha)
          rx_bclk <= 1'b0;
      end
    end
  end
endmodule : ptf_line_peer

// file: rtl/ptf_expander.sv
// Purpose: Registered inverse companding of one received word to linear
// Assumes: Sign-magnitude word, segment plus step code, 14-bit result in half steps
// Notes: One word per strobe, result one cycle later, order kept
`timescale 1ns/1ps
module ptf_expander
  import ptf_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset
  input wire logic in_vld, // Word strobe
  input wire logic [7:0] in_word, // Received voice word
  input wire logic in_half, // LSB stolen for signalling
  output logic out_vld, // Sample strobe
  output logic signed [14:0] out_smp // Midpoint amplitude
);
  logic out_vld_r, out_vld_nxt;
  logic signed [14:0] smp_r, smp_nxt;

  // Midpoint of interval in half units; stolen LSB becomes exactly one half
  function automatic logic [13:0] mid_mag(input logic [7:0] w, input logic half);
    logic [2:0] chord;
    logic [4:0] stp2;
    logic [13:0] m;
    chord = w[CHORD_HI:CHORD_LO];
    stp2 = half ? {w[3:1], 2'b10} : {w[3:0], 1'b1};
    m = {9'h000, stp2} + 14'h0020; // Chord base plus midpoint
    m = m << chord;
    return m;
  endfunction : mid_mag

  // Next sample; sign from polarity bit
  always_comb
  begin
    out_vld_nxt = in_vld;
    smp_nxt = smp_r;
    if (in_vld)
    begin
      if (in_word[POS_BIT])
        smp_nxt = $signed({1'b0, mid_mag(in_word, in_half)});
      else
        smp_nxt = -$signed({1'b0, mid_mag(in_word, in_half)});
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      out_vld_r <= 1'b0;
      smp_r <= 15'sh0000;
    end
    else
    begin
      out_vld_r <= out_vld_nxt;
      smp_r <= smp_nxt;
    end
  end

  assign out_vld = out_vld_r;
  assign out_smp = smp_r;

  property p_order;
    @(posedge clk_sys) disable iff (srst) in_vld |=> out_vld;
  endproperty
  a_order: assert property (p_order) else $error("sample strobe missing");

  property p_half;
    @(posedge clk_sys) disable iff (srst)
      (in_vld && in_half && in_word[POS_BIT]) |=> (out_smp[0] == 1'b0);
  endproperty
  a_half: assert property (p_half) else $error("half value wrong");

  property p_sign;
    @(posedge clk_sys) disable iff (srst)
      (in_vld && !in_word[POS_BIT]) |=> out_smp < 0;
  endproperty
  a_sign: assert property (p_sign) else $error("polarity wrong");

  property p_mid;
    @(posedge clk_sys) disable iff (srst)
      (in_vld && !in_half && in_word[POS_BIT] && in_word[6:4] == 3'd0)
        |=> out_smp[0] == 1'b1;
  endproperty
  a_mid: assert property (p_mid) else $error("not a midpoint");
endmodule : ptf_expander

// file: rtl/ptf_framer.sv
// Purpose: TDM frame builder and parser for 24-slot and 32-slot formats
// Assumes: Channel words are sampled at slot start; line input is a pin
// Notes: Transmit AMI coded; receive takes NRZ bits plus a frame mark
`timescale 1ns/1ps
module ptf_framer
  import ptf_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset
  input wire logic fmt_long, // 1 = 32-slot format
  input wire logic [7:0] tx_word, // Word for the slot after tx_slot
  input wire logic tx_sig, // Signalling bit for current slot
  output logic [4:0] tx_slot, // Slot whose word was just taken
  output logic tx_take, // Pulse: tx_word taken
  output logic line_pos, // AMI positive mark
  output logic line_neg, // AMI negative mark
  output logic line_nrz, // NRZ before line coding
  output logic line_bclk_en, // Pulse per line bit
  input wire logic rx_bit_pin, // Received NRZ bit
  input wire logic rx_bclk_pin, // Received bit strobe level
  input wire logic rx_fsync_pin, // High on framing position bit
  output logic rx_vld, // Pulse: rx word ready
  output logic [4:0] rx_slot, // Slot of rx word
  output logic [7:0] rx_word, // Received word, inversion undone
  output logic received_signalling_output, // Latched signalling bit
  output logic smp_vld, // Pulse: decoded sample
  output logic signed [14:0] smp_out // Decoded sample
);
  // Transmit state
  logic [23:0] acc_r, acc_nxt;
  logic ben_r, ben_nxt;
  logic [8:0] tbit_r, tbit_nxt;
  logic [7:0] tsh_r, tsh_nxt;
  logic [2:0] tfc_r, tfc_nxt;
  logic nrz_r, nrz_nxt;
  logic pos_r, pos_nxt, neg_r, neg_nxt, last_r, last_nxt;
  logic take_r, take_nxt;
  logic [4:0] tslot_r, tslot_nxt;
  logic fbit_r, fbit_nxt;
  logic [8:0] flen;
  // Receive synchronisers and state
  logic [2:0] s1_r, s2_r;
  logic bclk_d_r;
  logic [8:0] rbit_r, rbit_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic [2:0] rfc_r, rfc_nxt;
  logic rvld_r, rvld_nxt;
  logic [4:0] rslot_r, rslot_nxt;
  logic [7:0] rword_r, rword_nxt;
  logic sigo_r, sigo_nxt;
  logic half_r, half_nxt;
  logic rx_edge;

  // Frame length selects the bit counter wrap
  function automatic logic [8:0] frame_len(input logic lng);
    return lng ? BITS_LONG : BITS_SHORT;
  endfunction : frame_len

  // Alternate-bit inversion for the long format only
  function automatic logic [7:0] alt_inv(input logic lng, input logic [7:0] w);
    return lng ? (w ^ INV_MASK) : w;
  endfunction : alt_inv

  assign flen = frame_len(fmt_long);

  // Transmit next state: bit clock, slot sequencing, serialiser, AMI
  always_comb
  begin
    logic [24:0] sum;
    logic [8:0] b;
    logic [7:0] w;
    sum = 25'h0000000;
    b = 9'h000;
    w = 8'h00;
    sum = {1'b0, acc_r} + {1'b0, (fmt_long ? STEP_LONG : STEP_SHORT)};
    acc_nxt = sum[23:0];
    ben_nxt = sum[24];
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    tfc_nxt = tfc_r;
    nrz_nxt = nrz_r;
    pos_nxt = 1'b0;
    neg_nxt = 1'b0;
    last_nxt = last_r;
    take_nxt = 1'b0;
    tslot_nxt = tslot_r;
    fbit_nxt = fbit_r;
    if (ben_r)
    begin
      // Frame length bits every 125 us at the chosen rate
      b = (tbit_r + 9'd1 >= flen) ? 9'h000 : tbit_r + 9'd1;
      tbit_nxt = b;
      if (b == 9'h000)
        tfc_nxt = (tfc_r == 3'(SIG_FRAME_EVERY - 1)) ? 3'd0 : tfc_r + 3'd1;
      if (!fmt_long && b == 9'd192)
      begin
        nrz_nxt = fbit_r; // Framing bit after slot 23
        fbit_nxt = ~fbit_r;
      end
      else if (b[2:0] == 3'd0)
      begin
        tslot_nxt = b[7:3];
        take_nxt = 1'b1;
        w = tx_word;
        if (fmt_long && b[7:3] == SLOT_SYNC)
          w = SYNC_WORD;
        else if (fmt_long && b[7:3] == SLOT_SIG)
          w = SIG_SLOT_IDLE;
        else if (!fmt_long && tfc_nxt == 3'd0) // Count of frame just begun, robs whole frame
          w = {tx_word[7:1], tx_sig}; // LSB only
        w = alt_inv(fmt_long, w);
        nrz_nxt = w[7];
        tsh_nxt = {w[6:0], 1'b0};
      end
      else
      begin
        nrz_nxt = tsh_r[7];
        tsh_nxt = {tsh_r[6:0], 1'b0};
      end
      // AMI: marks alternate polarity, spaces stay at zero
      if (nrz_nxt)
      begin
        pos_nxt = ~last_r;
        neg_nxt = last_r;
        last_nxt = ~last_r;
      end
    end
    else
    begin
      pos_nxt = pos_r;
      neg_nxt = neg_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      acc_r <= 24'h000000;
      ben_r <= 1'b0;
      tbit_r <= 9'h1ff;
      tsh_r <= 8'h00;
      tfc_r <= 3'd0;
      nrz_r <= 1'b0;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
      last_r <= 1'b0;
      take_r <= 1'b0;
      tslot_r <= 5'd0;
      fbit_r <= 1'b1;
    end
    else
    begin
      acc_r <= acc_nxt;
      ben_r <= ben_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      tfc_r <= tfc_nxt;
      nrz_r <= nrz_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      last_r <= last_nxt;
      take_r <= take_nxt;
      tslot_r <= tslot_nxt;
      fbit_r <= fbit_nxt;
    end
  end

  // Two-stage pin synchronisers: bit, strobe, frame mark
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_r <= 3'b000;
      s2_r <= 3'b000;
      bclk_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {rx_fsync_pin, rx_bclk_pin, rx_bit_pin};
      s2_r <= s1_r;
      bclk_d_r <= s2_r[1];
    end
  end

  assign rx_edge = s2_r[1] & ~bclk_d_r;

  // Receive parser: frame mark realigns the counter, words assemble MSB first
  always_comb
  begin
    logic [7:0] w;
    logic [8:0] b;
    w = 8'h00;
    b = 9'h000;
    rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;
    rfc_nxt = rfc_r;
    rvld_nxt = 1'b0;
    rslot_nxt = rslot_r;
    rword_nxt = rword_r;
    sigo_nxt = sigo_r;
    half_nxt = 1'b0;
    if (rx_edge)
    begin
      // Framing position loads count, 0 in long format or 192 in short; otherwise modulo frame
      if (s2_r[2])
        b = fmt_long ? 9'h000 : 9'd192;
      else
        b = (rbit_r + 9'd1 >= flen) ? 9'h000 : rbit_r + 9'd1;
      rbit_nxt = b;
      if (b == 9'h000)
        rfc_nxt = (rfc_r == 3'(SIG_FRAME_EVERY - 1)) ? 3'd0 : rfc_r + 3'd1;
      if (fmt_long || b != 9'd192)
      begin
        w = {rsh_r[6:0], s2_r[0]};
        rsh_nxt = w;
        if (b[2:0] == 3'd7)
        begin
          w = alt_inv(fmt_long, w); // Undo inversion
          rvld_nxt = 1'b1; // Arrival order kept
          rslot_nxt = b[7:3];
          rword_nxt = w;
          if (!fmt_long && rfc_r == 3'd0)
          begin
            sigo_nxt = w[0];
            half_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rbit_r <= 9'd192;
      rsh_r <= 8'h00;
      rfc_r <= 3'd0;
      rvld_r <= 1'b0;
      rslot_r <= 5'd0;
      rword_r <= 8'h00;
      sigo_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;
      rfc_r <= rfc_nxt;
      rvld_r <= rvld_nxt;
      rslot_r <= rslot_nxt;
      rword_r <= rword_nxt;
      sigo_r <= sigo_nxt;
      half_r <= half_nxt;
    end
  end

  // Voice decode; sync and signalling slots still pass, user filters by slot
  ptf_expander u_exp (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_vld(rvld_r),
    .in_word(rword_r),
    .in_half(half_r),
    .out_vld(smp_vld),
    .out_smp(smp_out)
  );

  assign tx_slot = tslot_r;
  assign tx_take = take_r;
  assign line_pos = pos_r;
  assign line_neg = neg_r;
  assign line_nrz = nrz_r;
  assign line_bclk_en = ben_r;
  assign rx_vld = rvld_r;
  assign rx_slot = rslot_r;
  assign rx_word = rword_r;
  assign received_signalling_output = sigo_r;

  property p_ami;
    @(posedge clk_sys) disable iff (srst) !(line_pos && line_neg);
  endproperty
  a_ami: assert property (p_ami) else $error("both AMI marks");

  property p_wrap;
    @(posedge clk_sys) disable iff (srst)
      (ben_r && tbit_r == flen - 9'd1) |=> tbit_r == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame length wrong");

  property p_sync;
    @(posedge clk_sys) disable iff (srst)
      (ben_r && fmt_long && tbit_r == 9'd255 && $stable(fmt_long))
        |=> nrz_r == (SYNC_WORD[7] ^ INV_MASK[7]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync slot wrong");

  property p_sig;
    @(posedge clk_sys) disable iff (srst)
      (rvld_nxt && half_nxt) |=> received_signalling_output == rx_word[0];
  endproperty
  a_sig: assert property (p_sig) else $error("signalling not latched");

  property p_fmark;
    @(posedge clk_sys) disable iff (srst)
      (rx_edge && s2_r[2] && !fmt_long) |=> rbit_r == 9'd192;
  endproperty
  a_fmark: assert property (p_fmark) else $error("frame realign failed");

  property p_take;
    @(posedge clk_sys) disable iff (srst) tx_take |-> tx_slot != 5'd24 || fmt_long;
  endproperty
  a_take: assert property (p_take) else $error("slot beyond 24");

  property p_dec;
    @(posedge clk_sys) disable iff (srst) rx_vld |=> smp_vld;
  endproperty
  a_dec: assert property (p_dec) else $error("decode dropped");

  property p_rate;
    @(posedge clk_sys) disable iff (srst) ben_r |=> !ben_r;
  endproperty
  a_rate: assert property (p_rate) else $error("bit enable too fast");

  c_long: cover property (@(posedge clk_sys) fmt_long && tx_take && tx_slot == SLOT_SIG);
  c_fbit: cover property (@(posedge clk_sys) !fmt_long && ben_r && tbit_r == 9'd192);
  c_sig: cover property (@(posedge clk_sys) rx_vld && half_r);
endmodule : ptf_framer

// file: shared/ptf_pkg.sv
// Purpose: Constants and types for the TDM voice frame builder and parser
// Assumes: 100 MHz system clock; line bit rates made by fractional dividers
// Notes: No software registers; mode select is a plain input
// How it works
// - Short format: 24 eight-bit slots plus one framing bit, 193 bits.
// - Framing bit sits after the last slot, keeps receiver counter aligned.
// - Short format signalling rides only in word bit 8, the LSB.
// - Short format serialized at 1.544 MHz line bit rate.
// - Long format: 32 slots, 30 voice, one sync/alarm, one signalling.
// - Long format slot 0 carries sync/alarm word, slot 16 signalling word.
// - Long format inverts bit positions 2, 4, 6, 8 on send and receive.
// - Long format: 256 bits per frame at 2.048 MHz.
// - NRZ stream passes through AMI line coding to a DC-free ternary signal.
// - Short format signalling frame: received LSB latched onto signalling output.
// - Stolen signalling LSB is treated as one half when rebuilding the sample.
// - Received words are decoded strictly in arrival order.
// - Each word maps to its quantizing interval midpoint by inverse companding.
// - Word layout: polarity MSB (1 positive), three chord bits, four step bits.
// - Every channel supplies one word per 8 kHz, 125 us frame.
package ptf_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned RATE_SHORT_HZ = 1544000;
  localparam int unsigned RATE_LONG_HZ = 2048000;
  localparam int unsigned FRAME_HZ = 8000;
  localparam logic [8:0] BITS_SHORT = 9'd193;
  localparam logic [8:0] BITS_LONG = 9'd256;
  localparam logic [4:0] SLOTS_SHORT = 5'd24;
  localparam logic [4:0] SLOT_SYNC = 5'd0;
  localparam logic [4:0] SLOT_SIG = 5'd16;
  localparam logic [7:0] INV_MASK = 8'h55; // Bits 2,4,6,8 counted from MSB as bit 1
  localparam logic [7:0] SYNC_WORD = 8'h1b;
  localparam logic [7:0] SIG_SLOT_IDLE = 8'h0b;
  localparam int unsigned SIG_FRAME_EVERY = 6; // Every sixth short frame robs the LSB
  // Phase accumulator steps: bit enable rate = step / 2^24 * CLK_HZ
  localparam logic [23:0] STEP_SHORT =
    24'((64'(RATE_SHORT_HZ) << 24) / 64'(CLK_HZ));
  localparam logic [23:0] STEP_LONG =
    24'((64'(RATE_LONG_HZ) << 24) / 64'(CLK_HZ));
  localparam int unsigned POS_BIT = 7;
  localparam int unsigned CHORD_HI = 6;
  localparam int unsigned CHORD_LO = 4;

  typedef struct packed {
    logic [4:0] slot;
    logic [7:0] word;
  } ptf_word_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } ptf_ami_t;
endpackage : ptf_pkg
